// ---- axis_buffer_and_bias_null_regs.sv ----
// Serial register slave with per-axis capture buffers and x bias nulling
`timescale 1ns/10ps
`default_nettype none

// Behaviour
// - X register shows sample at index
// - Streaming mode leaves buffer registers untouched
// - Completed word read advances index, reloads
// - Time capture: 4096 samples, index 0..4095
// - Spectral: 2048 bins, index 0..2047
// - X reads 0x8000 during first capture
// - Y and Z read zero until first capture
// - Mode field: 00,01 spectral, 10 time
// - Time samples are signed 16-bit words
// - Spectral values are unsigned 16-bit words
// - Y and Z carry their own axes
// - Bit 4 puts root-sum-square in Z
// - X offset correction: host writable, drives chain
// - Command bit 0 starts auto-null
// - Offset clears at power-up or loads flash
// - Auto-null averages 4096 full-rate samples
// - Auto-null finishes within about 16 ms
// - Index clears after capture, wraps at max
// - Index write reloads all three registers
module axis_buffer_and_bias_null_regs #(
    parameter int AUTONULL_CYCLES = axis_buf_pkg::AUTONULL_CYCLES
) (
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic mosi,
    output logic miso,
    input wire logic capture_start,
    input wire logic capture_done,
    input wire logic cap_we,
    input wire logic [11:0] cap_index,
    input wire logic [15:0] cap_x,
    input wire logic [15:0] cap_y,
    input wire logic [15:0] cap_z,
    input wire logic [15:0] cap_rss,
    input wire logic sample_strobe,
    input wire logic [15:0] sample_x,
    input wire logic flash_valid,
    input wire logic [15:0] flash_x_offset,
    output logic [15:0] x_offset_correction,
    output logic [15:0] recording_control,
    output logic autonull_busy
);

    // Highest index for the current mode
    function automatic logic [11:0] index_limit(input logic [1:0] mode);
        if (mode == axis_buf_pkg::MODE_TIME_CAPTURE) begin
            index_limit = axis_buf_pkg::INDEX_MAX_TIME;
        end else begin
            index_limit = axis_buf_pkg::INDEX_MAX_SPECTRAL;
        end
    endfunction

    // Merge one written byte into a 16-bit register
    function automatic logic [15:0] put_byte(input logic [15:0] old, input logic hi,
                                             input logic [7:0] data);
        put_byte = hi ? {data, old[7:0]} : {old[15:8], data};
    endfunction

    // Same register pair, ignoring the byte select
    function automatic logic same_reg(input logic [6:0] a, input logic [6:0] b);
        same_reg = (a[6:1] == b[6:1]);
    endfunction

    // Link side: bit counter, receive shifter, transmit shifter
    logic link_rst_n; // Frame logic clears while select is high
    logic [3:0] bit_cnt_q;
    logic [14:0] rx_q;
    logic [15:0] frame_q; // Last whole frame, held until the next one
    logic frame_tog_q; // Toggles once per completed frame
    logic [15:0] tx_q;
    logic miso_q;

    // Core side: frame crossing and decode
    logic tog_s1_q, tog_s2_q, tog_s3_q;
    logic frame_evt;
    logic frame_wr;
    logic [6:0] frame_addr;
    logic [7:0] frame_data;
    logic [6:0] rd_addr_q; // Address whose word goes out next frame
    logic pend_q; // Current frame carries a buffer word out
    logic [15:0] resp_q; // Quasi-static: stable while a frame runs

    // Registers and buffers
    logic [15:0] recording_control_q;
    logic [1:0] mode;
    logic streaming;
    logic [15:0] x_offset_q;
    logic init_done_q;
    logic seen_first_q; // First capture done or streaming begun
    logic [11:0] index_q;
    logic load_q, load2_q;
    logic [15:0] x_mem [0:axis_buf_pkg::BUF_DEPTH-1];
    logic [15:0] y_mem [0:axis_buf_pkg::BUF_DEPTH-1];
    logic [15:0] z_mem [0:axis_buf_pkg::BUF_DEPTH-1];
    logic [15:0] rd_x_q, rd_y_q, rd_z_q;
    logic [15:0] x_buf_q, y_buf_q, z_buf_q;

    // Auto-null
    axis_buf_pkg::autonull_state_t an_state_q;
    logic [axis_buf_pkg::ACC_W-1:0] an_acc_q;
    logic [axis_buf_pkg::ACC_W-1:0] an_sum;
    logic [11:0] an_cnt_q;
    logic [axis_buf_pkg::TIMER_W-1:0] an_timer_q;
    logic an_load_q; // One-cycle pulse with the new correction
    logic [15:0] an_value_q;
    logic an_busy_q;
    logic an_start;

    assign link_rst_n = resetn & ~cs_n;

    // Shift in on rising edge; frame word handed over by a toggle
    always_ff @(posedge sclk or negedge link_rst_n) begin
        if (!link_rst_n) begin
            bit_cnt_q <= 4'h0;
            rx_q <= 15'h0000;
        end else begin
            bit_cnt_q <= bit_cnt_q + 4'h1;
            rx_q <= {rx_q[13:0], mosi};
        end
    end

    // Frame word and toggle survive select; only power reset clears them
    always_ff @(posedge sclk or negedge resetn) begin
        if (!resetn) begin
            frame_q <= 16'h0000;
            frame_tog_q <= 1'b0;
        end else if (bit_cnt_q == 4'(axis_buf_pkg::FRAME_BITS - 1)) begin
            frame_q <= {rx_q, mosi};
            frame_tog_q <= ~frame_tog_q;
        end
    end

    // Drive out on falling edge; the first falling edge takes the answer word
    always_ff @(negedge sclk or negedge link_rst_n) begin
        if (!link_rst_n) begin
            tx_q <= 16'h0000;
            miso_q <= 1'b0;
        end else if (bit_cnt_q == 4'h0) begin
            tx_q <= {resp_q[14:0], 1'b0};
            miso_q <= resp_q[15];
        end else begin
            tx_q <= {tx_q[14:0], 1'b0};
            miso_q <= tx_q[15];
        end
    end

    assign miso = miso_q;

    // Two-flop synchroniser plus edge stage for the frame toggle
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            tog_s1_q <= 1'b0;
            tog_s2_q <= 1'b0;
            tog_s3_q <= 1'b0;
        end else begin
            tog_s1_q <= frame_tog_q;
            tog_s2_q <= tog_s1_q;
            tog_s3_q <= tog_s2_q;
        end
    end

    // Frame word is stable for a whole frame after its toggle
    assign frame_evt = tog_s2_q ^ tog_s3_q;
    assign frame_wr = frame_q[axis_buf_pkg::FRAME_WRITE_BIT];
    assign frame_addr = frame_q[14:8];
    assign frame_data = frame_q[7:0];
    assign mode = recording_control_q[1:0];
    assign streaming = (mode == axis_buf_pkg::MODE_STREAMING);

    // Read request decode: word goes out in the following frame
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            rd_addr_q <= 7'h00;
            pend_q <= 1'b0;
        end else if (frame_evt) begin
            if (!frame_wr) begin
                rd_addr_q <= frame_addr;
            end
            // Both bytes travel in one word, so one frame completes the pair
            pend_q <= !frame_wr && (same_reg(frame_addr, axis_buf_pkg::ADDR_X_BUF)
                || same_reg(frame_addr, axis_buf_pkg::ADDR_Y_BUF)
                || same_reg(frame_addr, axis_buf_pkg::ADDR_Z_BUF));
        end
    end

    // Answer word follows any change within a few cycles
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            resp_q <= 16'h0000;
        end else if (same_reg(rd_addr_q, axis_buf_pkg::ADDR_SAMPLE_INDEX)) begin
            resp_q <= {4'h0, index_q};
        end else if (same_reg(rd_addr_q, axis_buf_pkg::ADDR_X_BUF)) begin
            resp_q <= x_buf_q;
        end else if (same_reg(rd_addr_q, axis_buf_pkg::ADDR_Y_BUF)) begin
            resp_q <= y_buf_q;
        end else if (same_reg(rd_addr_q, axis_buf_pkg::ADDR_Z_BUF)) begin
            resp_q <= z_buf_q;
        end else if (same_reg(rd_addr_q, axis_buf_pkg::ADDR_X_OFFSET)) begin
            resp_q <= x_offset_q;
        end else if (same_reg(rd_addr_q, axis_buf_pkg::ADDR_RECORDING_CONTROL)) begin
            resp_q <= recording_control_q;
        end else begin
            resp_q <= 16'h0000; // Unmapped reads return zero
        end
    end

    // Recording control, written a byte at a time
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            recording_control_q <= axis_buf_pkg::RECORDING_CONTROL_RESET;
        end else if (frame_evt && frame_wr
                     && same_reg(frame_addr, axis_buf_pkg::ADDR_RECORDING_CONTROL)) begin
            recording_control_q <= put_byte(recording_control_q, frame_addr[0], frame_data);
        end
    end

    assign recording_control = recording_control_q;

    // Defaults hold until the first capture ends or streaming starts
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            seen_first_q <= 1'b0;
        end else if (capture_done || streaming) begin
            seen_first_q <= 1'b1;
        end
    end

    // Index: clear on capture end, load on host write, advance after a read
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            index_q <= 12'h000;
            load_q <= 1'b0;
        end else if (capture_done) begin
            index_q <= 12'h000;
            load_q <= 1'b1;
        end else if (frame_evt && frame_wr
                     && same_reg(frame_addr, axis_buf_pkg::ADDR_SAMPLE_INDEX)) begin
            // Upper four written bits are ignored
            index_q <= (frame_addr[0] ? {frame_data[3:0], index_q[7:0]}
                                      : {index_q[11:8], frame_data})
                       & index_limit(mode);
            load_q <= 1'b1;
        end else if (frame_evt && pend_q && !streaming) begin
            if (index_q >= index_limit(mode)) begin
                index_q <= 12'h000;
            end else begin
                index_q <= index_q + 12'h001;
            end
            load_q <= 1'b1;
        end else begin
            load_q <= 1'b0;
        end
    end

    // Capture fills the buffers; Z holds the combined value when enabled
    always_ff @(posedge core_clk) begin
        if (cap_we) begin
            x_mem[cap_index] <= cap_x;
            y_mem[cap_index] <= cap_y;
            if (recording_control_q[axis_buf_pkg::REC_RSS_BIT]) begin
                z_mem[cap_index] <= cap_rss;
            end else begin
                z_mem[cap_index] <= cap_z;
            end
        end
    end

    // Synchronous buffer read at the current index
    always_ff @(posedge core_clk) begin
        rd_x_q <= x_mem[index_q];
        rd_y_q <= y_mem[index_q];
        rd_z_q <= z_mem[index_q];
    end

    // Delay the reload until the read data belongs to the new index
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            load2_q <= 1'b0;
        end else begin
            load2_q <= load_q;
        end
    end

    // Buffer access registers
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            x_buf_q <= axis_buf_pkg::BUF_RESET;
            y_buf_q <= axis_buf_pkg::BUF_RESET;
            z_buf_q <= axis_buf_pkg::BUF_RESET;
        end else if (capture_start && !seen_first_q) begin
            x_buf_q <= axis_buf_pkg::X_CAPTURE_DEFAULT;
            y_buf_q <= axis_buf_pkg::YZ_CAPTURE_DEFAULT;
            z_buf_q <= axis_buf_pkg::YZ_CAPTURE_DEFAULT;
        end else if (load2_q && seen_first_q && !streaming) begin
            // Streaming bypasses these registers entirely
            x_buf_q <= rd_x_q;
            y_buf_q <= rd_y_q;
            z_buf_q <= rd_z_q;
        end
    end

    // Flash value is caught on the first edge after reset release
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            init_done_q <= 1'b0;
        end else begin
            init_done_q <= 1'b1;
        end
    end

    // X offset: flash at start-up, then auto-null, then host bytes
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            x_offset_q <= axis_buf_pkg::X_OFFSET_RESET;
        end else if (!init_done_q) begin
            if (flash_valid) begin
                x_offset_q <= flash_x_offset;
            end
        end else if (an_load_q) begin
            x_offset_q <= an_value_q;
        end else if (frame_evt && frame_wr
                     && same_reg(frame_addr, axis_buf_pkg::ADDR_X_OFFSET)) begin
            x_offset_q <= put_byte(x_offset_q, frame_addr[0], frame_data);
        end
    end

    assign x_offset_correction = x_offset_q;

    // Command write with the auto-null bit set starts a new average when the sequencer is idle
    assign an_start = frame_evt && frame_wr
        && same_reg(frame_addr, axis_buf_pkg::ADDR_GLOBAL_CMD)
        && !frame_addr[0] && frame_data[axis_buf_pkg::GCMD_AUTONULL_BIT];
    assign an_sum = an_acc_q + {{(axis_buf_pkg::ACC_W - 16){sample_x[15]}}, sample_x};

    // Auto-null: sum 4096 raw strobed samples, offset is minus the mean
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            an_state_q <= axis_buf_pkg::AN_IDLE;
            an_acc_q <= '0;
            an_cnt_q <= 12'h000;
            an_timer_q <= '0;
            an_load_q <= 1'b0;
            an_value_q <= 16'h0000;
            an_busy_q <= 1'b0;
        end else begin
            an_load_q <= 1'b0;
            case (an_state_q)
                axis_buf_pkg::AN_IDLE: begin
                    if (an_start) begin
                        an_state_q <= axis_buf_pkg::AN_COLLECT;
                        an_acc_q <= '0;
                        an_cnt_q <= 12'h000;
                        an_timer_q <= '0;
                        an_busy_q <= 1'b1;
                    end
                end
                axis_buf_pkg::AN_COLLECT: begin
                    an_timer_q <= an_timer_q + axis_buf_pkg::TIMER_W'(1);
                    if (sample_strobe) begin
                        an_acc_q <= an_sum;
                        an_cnt_q <= an_cnt_q + 12'h001;
                    end
                    if (sample_strobe && an_cnt_q == axis_buf_pkg::AUTONULL_LAST) begin
                        an_value_q <= 16'(-an_sum[axis_buf_pkg::ACC_W-1:
                                                 axis_buf_pkg::AUTONULL_SHIFT]);
                        an_load_q <= 1'b1;
                        an_state_q <= axis_buf_pkg::AN_IDLE;
                        an_busy_q <= 1'b0;
                    end else if (an_timer_q ==
                                 axis_buf_pkg::TIMER_W'(AUTONULL_CYCLES - 1)) begin
                        // A stalled sample stream must not hang the command
                        an_state_q <= axis_buf_pkg::AN_IDLE;
                        an_busy_q <= 1'b0;
                    end
                end
                default: begin
                    an_state_q <= axis_buf_pkg::AN_IDLE;
                    an_busy_q <= 1'b0;
                end
            endcase
        end
    end

    assign autonull_busy = an_busy_q;

endmodule

`default_nettype wire

// ---- axis_buf_pkg.sv ----
// Constants for the axis buffer access and x bias correction block
package axis_buf_pkg;
    // Byte addresses of the register map (each register is a byte pair)
    localparam logic [6:0] ADDR_SAMPLE_INDEX = 7'h0a;
    localparam logic [6:0] ADDR_X_BUF = 7'h0e;
    localparam logic [6:0] ADDR_Y_BUF = 7'h10;
    localparam logic [6:0] ADDR_Z_BUF = 7'h12;
    localparam logic [6:0] ADDR_X_OFFSET = 7'h14;
    localparam logic [6:0] ADDR_RECORDING_CONTROL = 7'h1a;
    localparam logic [6:0] ADDR_GLOBAL_CMD = 7'h3e;
    // Serial frame layout
    localparam int FRAME_BITS = 16;
    localparam int FRAME_WRITE_BIT = 15;
    // Recording mode codes
    localparam logic [1:0] MODE_MANUAL_SPECTRAL = 2'b00;
    localparam logic [1:0] MODE_AUTO_SPECTRAL = 2'b01;
    localparam logic [1:0] MODE_TIME_CAPTURE = 2'b10;
    localparam logic [1:0] MODE_STREAMING = 2'b11;
    // Recording control fields and the global command auto-null bit
    localparam int REC_RSS_BIT = 4;
    localparam int REC_VELOCITY_BIT = 5;
    localparam logic [15:0] RECORDING_CONTROL_RESET = 16'h1102;
    localparam int GCMD_AUTONULL_BIT = 0;
    // Reset and default register contents
    localparam logic [15:0] X_CAPTURE_DEFAULT = 16'h8000;
    localparam logic [15:0] YZ_CAPTURE_DEFAULT = 16'h0000;
    localparam logic [15:0] BUF_RESET = 16'h0000;
    localparam logic [15:0] X_OFFSET_RESET = 16'h0000;
    // Buffer depth, and per-mode depths as highest index
    localparam int BUF_DEPTH = 4096;
    localparam logic [11:0] INDEX_MAX_TIME = 12'h0fff;
    localparam logic [11:0] INDEX_MAX_SPECTRAL = 12'h07ff;
    // Auto-null averaging: 4096 samples, mean by shift of 12
    localparam logic [11:0] AUTONULL_LAST = 12'h0fff;
    localparam int ACC_W = 28;
    localparam int AUTONULL_SHIFT = 12;
    // Auto-null time allowance
    localparam int CLK_HZ = 100_000_000;
    localparam int AUTONULL_TIME_MS = 16;
    localparam int AUTONULL_CYCLES = AUTONULL_TIME_MS * (CLK_HZ / 1000);
    localparam int TIMER_W = 21;
    // Auto-null sequencer states
    typedef enum logic {AN_IDLE, AN_COLLECT} autonull_state_t;
endpackage

// ---- axis_buf_notes_unused.sv ----
// Spare source file, holds no logic of the block
`timescale 1ns/10ps
`default_nettype none
`default_nettype wire

// ---- axis_buffer_and_bias_null_regs_properties.sv ----
// Port checker for the axis buffer block, bound to the block at the foot
`timescale 1ns/10ps
`default_nettype none
module axis_buf_checker #(
    parameter int AUTONULL_CYCLES = 20000
) (
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic cs_n,
    input wire logic sample_strobe,
    input wire logic [15:0] sample_x,
    input wire logic flash_valid,
    input wire logic [15:0] flash_x_offset,
    input wire logic [15:0] x_offset_correction,
    input wire logic [15:0] recording_control,
    input wire logic autonull_busy
);
    logic [12:0] strb_q; // Strobes taken in this nulling run
    logic signed [27:0] acc_q; // Running sum of those samples
    logic [31:0] cyc_q; // Cycles spent busy
    logic [15:0] neg_mean; // Expected correction, negated mean
    assign neg_mean = 16'(-(acc_q >>> 12));
    // Counters restart whenever the sequencer is idle
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn || !autonull_busy) begin
            strb_q <= 13'h0000;
            acc_q <= 28'h000_0000;
            cyc_q <= 32'h0000_0000;
        end else begin
            cyc_q <= cyc_q + 32'h0000_0001;
            // Only strobes seen while busy belong to the run
            if (sample_strobe) begin
                strb_q <= strb_q + 13'h0001;
                acc_q <= acc_q + 28'(signed'(sample_x));
            end
        end
    end
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!resetn);
    // Link idle long enough for any write of the last frame to have landed
    sequence s_idle;
        cs_n [*8];
    endsequence
    a_flash_load: assert property (!$past(resetn) |=> x_offset_correction ==
        ($past(flash_valid) ? $past(flash_x_offset) : 16'h0000))
        else $error("offset not loaded at reset release");
    a_mode_reset: assert property (!$past(resetn) |->
        recording_control == axis_buf_pkg::RECORDING_CONTROL_RESET) else $error("mode reset value");
    a_null_count: assert property ($fell(autonull_busy) &&
        cyc_q < 32'(AUTONULL_CYCLES) - 32'h0000_0004 |-> strb_q == 13'h1000)
        else $error("nulling ended without 4096 samples");
    // The correction lands one edge after busy drops, when the counters have restarted
    a_null_value: assert property ($fell(autonull_busy) && strb_q == 13'h1000 |=>
        x_offset_correction == $past(neg_mean)) else $error("nulling result wrong");
    a_null_time: assert property (autonull_busy |->
        cyc_q <= 32'(AUTONULL_CYCLES) + 32'h0000_0002) else $error("nulling overran");
    a_offset_hold: assert property (s_idle ##0 !autonull_busy &&
        !$past(autonull_busy) && !$past(autonull_busy, 2) |-> $stable(x_offset_correction))
        else $error("offset moved");
    a_mode_hold: assert property (s_idle |-> $stable(recording_control))
        else $error("mode moved while link idle");
    a_busy_quiet: assert property (s_idle ##0 !autonull_busy |=> !autonull_busy)
        else $error("nulling began without a command");
endmodule
bind axis_buffer_and_bias_null_regs axis_buf_checker #(
    .AUTONULL_CYCLES(AUTONULL_CYCLES)
) i_axis_buf_checker (
    .core_clk(core_clk), .resetn(resetn), .cs_n(cs_n), .sample_strobe(sample_strobe),
    .sample_x(sample_x), .flash_valid(flash_valid), .flash_x_offset(flash_x_offset),
    .x_offset_correction(x_offset_correction), .recording_control(recording_control),
    .autonull_busy(autonull_busy)
);
`default_nettype wire

// ---- host_spi_model.sv ----
// Host serial master model for the register link, clock idles high
`timescale 1ns/10ps
`default_nettype none
module host_spi_model (
    output logic sclk,
    output logic cs_n,
    output logic mosi,
    input wire logic miso
);
    realtime half_ns = 62.5; // Half link period; the bench raises it for a slow host
    initial begin
        sclk = 1'b1;
        cs_n = 1'b1;
        mosi = 1'b1;
    end
    // One whole frame, MSB first; returns the answer to the previous frame
    task automatic xfer(input logic [15:0] din, output logic [15:0] dout);
        cs_n = 1'b0;
        #(half_ns);
        for (int i = 15; i >= 0; i--) begin
            sclk = 1'b0;
            mosi = din[i];
            #(half_ns);
            sclk = 1'b1;
            dout[i] = miso;
            #(half_ns);
        end
        cs_n = 1'b1;
        mosi = ~din[0]; // Released line must not keep showing the last bit
        #300; // Gap lets the answer word cross and settle
    endtask
endmodule
`default_nettype wire

// ---- axis_buffer_and_bias_null_regs_test.sv ----
// Self-checking bench for the axis buffer and x bias block
`timescale 1ns/10ps
`default_nettype none
module axis_buffer_and_bias_null_regs_test;
    logic core_clk; // Core clock, 100 MHz
    logic resetn;
    logic sclk, cs_n, mosi, miso; // Register link; sclk, cs_n and mosi driven by the host model
    logic cap_start, cap_done, cap_we, strobe, fvalid, busy;
    logic [11:0] cap_index;
    logic [15:0] cx, cy, cz, crss, sx, foff, x_off, rec_ctl, got, junk;
    int n_errors;
    int checked;
    axis_buffer_and_bias_null_regs #(.AUTONULL_CYCLES(20000))
        i_axis_buffer_and_bias_null_regs (
        .core_clk(core_clk), .resetn(resetn), .sclk(sclk), .cs_n(cs_n), .mosi(mosi),
        .miso(miso), .capture_start(cap_start), .capture_done(cap_done), .cap_we(cap_we),
        .cap_index(cap_index), .cap_x(cx), .cap_y(cy), .cap_z(cz), .cap_rss(crss),
        .sample_strobe(strobe), .sample_x(sx), .flash_valid(fvalid),
        .flash_x_offset(foff), .x_offset_correction(x_off), .recording_control(rec_ctl),
        .autonull_busy(busy)
    );
    host_spi_model i_host_spi_model (.sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso(miso));
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    // Value compare; case inequality so an unknown never matches
    task automatic chk(input logic [15:0] g, input logic [15:0] e, input string what);
        checked++;
        if (g !== e) begin
            n_errors++;
            $display("BAD %0t %s got %h want %h", $time, what, g, e);
        end
    endtask
    // Read: the word comes back in the following frame, which reads the index
    task automatic rd(input logic [6:0] a, input logic [15:0] e, input string what);
        i_host_spi_model.xfer({1'b0, a, 8'h00}, junk);
        i_host_spi_model.xfer({1'b0, 7'h0a, 8'h00}, got);
        chk(got, e, what);
    endtask
    // Write: low byte to the even address, then high byte to the odd one
    task automatic wr(input logic [6:0] a, input logic [15:0] d);
        i_host_spi_model.xfer({1'b1, a, d[7:0]}, junk);
        i_host_spi_model.xfer({1'b1, a | 7'h01, d[15:8]}, junk);
    endtask
    // Capture write of one row; each axis carries a nibble tag and the row
    task automatic fill(input logic [11:0] i);
        @(negedge core_clk);
        cap_we = 1'b1;
        cap_index = i;
        cx = {4'h1, i};
        cy = {4'h2, i};
        cz = {4'h3, i};
        crss = {4'h4, i};
        @(negedge core_clk);
        cap_we = 1'b0;
    endtask
    // One-cycle capture start or capture done pulse
    task automatic ev(input logic done);
        @(negedge core_clk);
        cap_start = !done;
        cap_done = done;
        @(negedge core_clk);
        cap_start = 1'b0;
        cap_done = 1'b0;
    endtask
    task automatic do_reset(input logic fv);
        @(negedge core_clk);
        resetn = 1'b0;
        fvalid = fv;
        repeat (6) @(negedge core_clk);
        resetn = 1'b1;
        repeat (4) @(negedge core_clk);
    endtask
    task automatic test_done();
        $display("Comparisons %0d, mismatches %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    // Hang guard, well beyond the expected run of about 250 us
    initial begin
        #600000;
        n_errors++;
        $display("BAD %0t watchdog expired", $time);
        test_done();
    end
    initial begin
        {resetn, cap_start, cap_done, cap_we, strobe, fvalid} = 6'h00;
        {cap_index, cx, cy, cz, crss, sx} = 92'h0;
        foff = 16'h1234;
        n_errors = 0;
        checked = 0;
        do_reset(1'b0);
        chk(x_off, axis_buf_pkg::X_OFFSET_RESET, "offset cleared");
        do_reset(1'b1);
        chk(x_off, 16'h1234, "offset from flash");
        rd(7'h14, 16'h1234, "offset read");
        rd(7'h1a, axis_buf_pkg::RECORDING_CONTROL_RESET, "mode reset");
        ev(1'b0);
        rd(7'h0e, axis_buf_pkg::X_CAPTURE_DEFAULT, "x during capture");
        rd(7'h10, 16'h0000, "y during capture");
        rd(7'h12, 16'h0000, "z during capture");
        for (int k = 0; k < 4; k++) fill(12'(k));
        fill(12'h7ff);
        fill(12'hfff);
        wr(7'h1a, 16'h1112);
        chk(rec_ctl, 16'h1112, "control out");
        fill(12'h003); // Row 3 taken with the combined value in z
        wr(7'h1a, 16'h1102);
        ev(1'b1);
        rd(7'h0e, 16'h1000, "x row 0");
        rd(7'h10, 16'h2001, "y row 1");
        rd(7'h12, 16'h3002, "z row 2");
        rd(7'h12, 16'h4003, "combined row 3");
        wr(7'h0a, 16'h0fff);
        rd(7'h0e, 16'h1fff, "x row 4095");
        rd(7'h0e, 16'h1000, "x wrap to 0");
        wr(7'h1a, 16'h1100);
        wr(7'h0a, 16'h0fff);
        rd(7'h10, 16'h27ff, "y bin 2047");
        rd(7'h10, 16'h2000, "y bin wrap");
        i_host_spi_model.half_ns = 200.0;
        wr(7'h1a, 16'h1101);
        wr(7'h0a, 16'h0801);
        rd(7'h0e, 16'h1001, "x bin 1 slow host");
        i_host_spi_model.half_ns = 62.5;
        wr(7'h1a, 16'h1103);
        rd(7'h0e, 16'h1002, "x held streaming");
        rd(7'h0e, 16'h1002, "x still held");
        wr(7'h1a, 16'h1102);
        wr(7'h14, 16'h0064);
        chk(x_off, 16'h0064, "offset written");
        rd(7'h14, 16'h0064, "offset read back");
        rd(7'h30, 16'h0000, "unmapped read");
        i_host_spi_model.xfer({1'b1, 7'h3e, 8'h01}, junk);
        chk({15'h0000, busy}, 16'h0001, "nulling started");
        // Mean of +48 and -16 is +16, so the correction is -16
        for (int k = 0; k < 4096; k++) begin
            @(negedge core_clk);
            strobe = 1'b1;
            sx = k[0] ? 16'hfff0 : 16'h0030;
            @(negedge core_clk);
            strobe = 1'b0;
        end
        for (int w = 0; w < 20 && busy !== 1'b0; w++) @(negedge core_clk);
        chk({15'h0000, busy}, 16'h0000, "nulling done");
        // The correction register takes the result one edge after busy drops
        @(negedge core_clk);
        chk(x_off, 16'hfff0, "nulling result");
        rd(7'h14, 16'hfff0, "nulled offset read");
        test_done();
    end
endmodule
`default_nettype wire
